// [berc_defs.vh]
// Shared constants for the bit error rate checker
`ifndef BERC_DEFS_VH
`define BERC_DEFS_VH

// Register offsets (word index on the plain register port)
`define BERC_A_CTRL      4'h0
`define BERC_A_CMD       4'h1
`define BERC_A_TGT_BITS  4'h2
`define BERC_A_TGT_ERRS  4'h3
`define BERC_A_RESYNC    4'h4
`define BERC_A_CUSTOM    4'h5
`define BERC_A_STATUS    4'h6
`define BERC_A_RXCNT     4'h7
`define BERC_A_ERRCNT    4'h8
`define BERC_A_SLCNT     4'h9
`define BERC_A_IFACE     4'hA

// Control register fields
`define BERC_F_PAT_LO    0
`define BERC_F_PAT_HI    3
`define BERC_F_MODE_LO   4
`define BERC_F_MODE_HI  5
`define BERC_F_BASIS     6
`define BERC_F_RESYNC_ON 7
`define BERC_F_SL_CLEAR  8

// Command register bits
`define BERC_C_START     0
`define BERC_C_STOP      1
`define BERC_C_CLEAR     2

// Pattern codes
`define BERC_P_PN9       4'h0
`define BERC_P_PN11      4'h1
`define BERC_P_PN15      4'h2
`define BERC_P_PN20      4'h3
`define BERC_P_PN23      4'h4
`define BERC_P_PN9F      4'h5
`define BERC_P_PN11F     4'h6
`define BERC_P_PN15F     4'h7
`define BERC_P_PN20F     4'h8
`define BERC_P_PN23F     4'h9
`define BERC_P_ZEROS     4'hA
`define BERC_P_ONES      4'hB
`define BERC_P_ALT       4'hC
`define BERC_P_CUSTOM    4'hD

// Run modes
`define BERC_M_SINGLE    2'h0
`define BERC_M_CONT      2'h1
`define BERC_M_ENDLESS   2'h2

// Window sizes for sync-loss detection
`define BERC_W_500       2'h0
`define BERC_W_5000      2'h1
`define BERC_W_50000     2'h2

// Window lengths in bits
`define BERC_Y_500       16'h01F4
`define BERC_Y_5000      16'h1388
`define BERC_Y_50000     16'hC350

// Reset values and limits
`define BERC_RST_CTRL    9'h080
`define BERC_RST_TGTB    32'h000186A0
`define BERC_RST_TGTE    32'h00000001
`define BERC_RST_RESYNC  32'h000000C8
`define BERC_MAX32       32'hFFFFFFFF
`define BERC_MAX16       16'hFFFF
`define BERC_SYNC_RUN    6'h20

`endif

// [berc_sync.v]
// Two-flop synchroniser for signals arriving from outside the clock domain
`default_nettype none
module berc_sync #(
    parameter W = 3
) (
    input  wire         clk_i,
    input  wire         arst_n_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_r <= {W{1'b0}};
            q_o    <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule
`default_nettype wire

// [berc_refgen.v]
// Reference pattern generator with self-seeding from received bits
`include "berc_defs.vh"
`default_nettype none
module berc_refgen (
    input  wire        clk_i,
    input  wire        arst_n_i,
    input  wire        restart_i,
    input  wire        step_i,
    input  wire        seed_i,
    input  wire        rx_bit_i,
    input  wire [3:0]  pat_i,
    input  wire [31:0] custom_i,
    output reg         ref_o
);
    reg  [22:0] lfsr_r;
    reg  [4:0]  pos_r;
    reg         alt_r;
    reg         fb;
    reg  [3:0]  ord;

    // Feedback taps of the maximal-length polynomials; Fix variants share them
    always @*
    begin
        ord = (pat_i >= `BERC_P_PN9F && pat_i <= `BERC_P_PN23F) ? pat_i - 4'h5 : pat_i;
        case (ord)
            `BERC_P_PN9:  fb = lfsr_r[8]  ^ lfsr_r[4];
            `BERC_P_PN11: fb = lfsr_r[10] ^ lfsr_r[8];
            `BERC_P_PN15: fb = lfsr_r[14] ^ lfsr_r[13];
            `BERC_P_PN20: fb = lfsr_r[19] ^ lfsr_r[16];
            `BERC_P_PN23: fb = lfsr_r[22] ^ lfsr_r[17];
            default:      fb = 1'b0;
        endcase
    end

    // Expected bit for the current position
    always @*
    begin
        case (pat_i)
            `BERC_P_ZEROS:  ref_o = 1'b0;
            `BERC_P_ONES:   ref_o = 1'b1;
            `BERC_P_ALT:    ref_o = alt_r;
            `BERC_P_CUSTOM: ref_o = custom_i[pos_r];
            default:        ref_o = fb;
        endcase
    end

    // While seeding, received bits fill the shift register to lock the phase
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            lfsr_r <= 23'h000000;
            pos_r  <= 5'h00;
            alt_r  <= 1'b0;
        end
        else if (restart_i)
        begin
            pos_r <= 5'h00;
            alt_r <= 1'b0;
        end
        else if (step_i)
        begin
            lfsr_r <= {lfsr_r[21:0], seed_i ? rx_bit_i : fb};
            pos_r  <= pos_r + 5'h01;
            alt_r  <= seed_i ? ~rx_bit_i : ~alt_r;
        end
    end
endmodule
`default_nettype wire

// [berc_top.v]
// Bit error rate checker: link sampling, comparison, counters and run control
//
// Function
// - Gate, data and data-synchronous clock arrive from outside; data sampled on link clock.
// - With gate unused, every clocked bit is compared and counted.
// - Patterns: PN9..PN23, fixed variants, zeros, ones, alternating, custom.
// - Alternating pattern is zero then one, repeated without break.
// - Single, continuous, endless modes; endless runs 2^32-1 bits ignoring targets.
// - Single/continuous stop on received-bit or error-bit target.
// - Bit basis stops when received count reaches target (1000..2^32-1).
// - Error basis stops when error count reaches target (1..2^31-1).
// - Error basis also stops when received count hits 2^32-1.
// - Resync on: stop when sync-loss count reaches 65535; off: no effect. Endless mode here never stops on it.
// - Start begins a run; stop halts it at once.
// - Writing a setting except interface settings during a run halts it.
// - Continuous mode restarts a new run after each termination.
// - After power-up the checker is stopped until a start arrives.
// - Sync loss is X errors within a window of 500, 5000 or 50000 bits.
// - On sync loss counting pauses while pattern sync is reacquired.
// - Option clears or keeps the received count on sync loss.
// - Count clear zeroes counts keeping sync; ignored in continuous mode.
//
// The placing of the registers and strobed register access were left to the implementer.
`include "berc_defs.vh"
`default_nettype none
module berc_top (
    input  wire        clk_i,
    input  wire        arst_n_i,
    input  wire        link_clk_i,
    input  wire        link_data_i,
    input  wire        link_gate_i,
    input  wire [3:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    output reg         running_o,
    output reg         synced_o
);
    // States of the run controller, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SYNC = 3'b010;
    localparam [2:0] ST_MEAS = 3'b100;

    //--------------------------------------------------------------
    // Link sampling
    //--------------------------------------------------------------
    wire [2:0] lk_s;
    reg        lclk_d_r;

    berc_sync #(.W(3)) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({link_clk_i, link_data_i, link_gate_i}),
        .q_o      (lk_s)
    );

    // Rising edge of the synchronised link clock marks a data bit
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            lclk_d_r <= 1'b0;
        else
            lclk_d_r <= lk_s[2];
    end

    reg [8:0]  ctrl_r;
    reg [31:0] tgt_bits_r;
    reg [31:0] tgt_errs_r;
    reg [31:0] resync_r;     // [15:0] threshold X, [17:16] window select
    reg [31:0] custom_r;
    reg        gate_used_r;  // Interface setting: does not halt a run

    wire [3:0] pat      = ctrl_r[`BERC_F_PAT_HI:`BERC_F_PAT_LO];
    wire [1:0] mode     = ctrl_r[`BERC_F_MODE_HI:`BERC_F_MODE_LO];
    wire       basis    = ctrl_r[`BERC_F_BASIS];
    wire       resync   = ctrl_r[`BERC_F_RESYNC_ON];
    wire       sl_clr   = ctrl_r[`BERC_F_SL_CLEAR];
    wire       bit_stb  = lk_s[2] & ~lclk_d_r;
    wire       bit_ok   = bit_stb & (~gate_used_r | lk_s[0]);
    wire       rx_bit   = lk_s[1];

    //--------------------------------------------------------------
    // Run control and counting
    //--------------------------------------------------------------
    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg [31:0] rx_cnt_r;
    reg [31:0] err_cnt_r;
    reg [15:0] sl_cnt_r;
    reg [15:0] win_pos_r;
    reg [15:0] win_err_r;
    reg [5:0]  sync_cnt_r;

    wire ref_bit;
    wire seeding  = state_r == ST_SYNC;
    wire measure  = state_r == ST_MEAS;
    wire mismatch = ref_bit ^ rx_bit;
    wire running  = ~state_r[0];

    wire cmd_wr   = wr_i & (addr_i == `BERC_A_CMD);
    wire start    = cmd_wr & wdata_i[`BERC_C_START];
    wire stop     = cmd_wr & wdata_i[`BERC_C_STOP];
    wire cnt_clr  = cmd_wr & wdata_i[`BERC_C_CLEAR] & (mode != `BERC_M_CONT);
    wire set_wr   = wr_i & (addr_i == `BERC_A_CTRL || addr_i == `BERC_A_TGT_BITS ||
                            addr_i == `BERC_A_TGT_ERRS || addr_i == `BERC_A_RESYNC ||
                            addr_i == `BERC_A_CUSTOM);

    wire [15:0] win_len = (resync_r[17:16] == `BERC_W_5000)  ? `BERC_Y_5000 :
                          (resync_r[17:16] == `BERC_W_50000) ? `BERC_Y_50000 : `BERC_Y_500;

    // Sync loss: X errors seen inside the current window of Y bits
    wire sl_event = resync & measure & bit_ok & mismatch &
                    (win_err_r + 16'h0001 >= resync_r[15:0]);

    // Termination conditions evaluated every cycle against the registered counts
    wire rx_full  = rx_cnt_r == `BERC_MAX32;
    wire term_endless = (mode == `BERC_M_ENDLESS) & rx_full;
    wire term_bits = (mode != `BERC_M_ENDLESS) & ~basis & (rx_cnt_r >= tgt_bits_r);
    wire term_errs = (mode != `BERC_M_ENDLESS) & basis &
                     ((err_cnt_r >= tgt_errs_r) | rx_full);
    wire term_sl  = (mode != `BERC_M_ENDLESS) & resync & (sl_cnt_r == `BERC_MAX16);
    wire term     = measure & (term_endless | term_bits | term_errs | term_sl);
    wire relaunch = term & (mode == `BERC_M_CONT);

    // Next state of the run controller
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (start)
                    state_nxt = ST_SYNC;
            ST_SYNC:
                if (stop | set_wr)
                    state_nxt = ST_IDLE;
                else if (sync_cnt_r == `BERC_SYNC_RUN)
                    state_nxt = ST_MEAS;
            ST_MEAS:
                if (stop | set_wr)
                    state_nxt = ST_IDLE;
                else if (relaunch)
                    state_nxt = ST_SYNC;
                else if (term)
                    state_nxt = ST_IDLE;
                else if (sl_event)
                    state_nxt = ST_SYNC;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // Reset always lands in idle, so a power cycle never resumes a run
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Sync acquisition: consecutive matching bits after seeding
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sync_cnt_r <= 6'h00;
        else if (~seeding)
            sync_cnt_r <= 6'h00;
        else if (bit_ok)
            sync_cnt_r <= mismatch ? 6'h00 : sync_cnt_r + 6'h01;
    end

    // Counters saturate instead of wrapping; start and relaunch clear them
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rx_cnt_r  <= 32'h00000000;
            err_cnt_r <= 32'h00000000;
            sl_cnt_r  <= 16'h0000;
        end
        else if ((state_r == ST_IDLE & start) | relaunch | cnt_clr)
        begin
            rx_cnt_r  <= 32'h00000000;
            err_cnt_r <= 32'h00000000;
            sl_cnt_r  <= 16'h0000;
        end
        else if (sl_event)
        begin
            if (sl_cnt_r != `BERC_MAX16)
                sl_cnt_r <= sl_cnt_r + 16'h0001;
            if (sl_clr)
                rx_cnt_r <= 32'h00000000;
        end
        else if (measure & bit_ok & ~term)
        begin
            if (!rx_full)
                rx_cnt_r <= rx_cnt_r + 32'h00000001;
            if (mismatch && err_cnt_r != `BERC_MAX32)
                err_cnt_r <= err_cnt_r + 32'h00000001;
        end
    end

    // Fixed block window for sync-loss detection
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            win_pos_r <= 16'h0000;
            win_err_r <= 16'h0000;
        end
        else if (~measure | sl_event)
        begin
            win_pos_r <= 16'h0000;
            win_err_r <= 16'h0000;
        end
        else if (bit_ok)
        begin
            if (win_pos_r + 16'h0001 >= win_len)
            begin
                win_pos_r <= 16'h0000;
                win_err_r <= 16'h0000;
            end
            else
            begin
                win_pos_r <= win_pos_r + 16'h0001;
                win_err_r <= win_err_r + {15'h0000, mismatch};
            end
        end
    end

    //--------------------------------------------------------------
    // Reference generator
    //--------------------------------------------------------------
    // Seeding on every mismatch while acquiring keeps the register true to the
    // stream, since a matching bit already equals the prediction. A custom word
    // cannot slip its phase, so its frames must start on bit 0.
    wire seed_now = seeding & mismatch;

    berc_refgen u_ref (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .restart_i (state_r == ST_IDLE),
        .step_i    (bit_ok & running),
        .seed_i    (seed_now),
        .rx_bit_i  (rx_bit),
        .pat_i     (pat),
        .custom_i  (custom_r),
        .ref_o     (ref_bit)
    );

    //--------------------------------------------------------------
    // Register port
    //--------------------------------------------------------------
    // Settings writes; the interface register is accepted at any time
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_r      <= `BERC_RST_CTRL;
            tgt_bits_r  <= `BERC_RST_TGTB;
            tgt_errs_r  <= `BERC_RST_TGTE;
            resync_r    <= `BERC_RST_RESYNC;
            custom_r    <= 32'h00000000;
            gate_used_r <= 1'b0;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `BERC_A_CTRL:     ctrl_r      <= wdata_i[8:0];
                `BERC_A_TGT_BITS: tgt_bits_r  <= wdata_i;
                `BERC_A_TGT_ERRS: tgt_errs_r  <= wdata_i;
                `BERC_A_RESYNC:   resync_r    <= {14'h0000, wdata_i[17:0]};
                `BERC_A_CUSTOM:   custom_r    <= wdata_i;
                `BERC_A_IFACE:    gate_used_r <= wdata_i[0];
                default:          ;
            endcase
        end
    end

    // Read data and status outputs, all registered
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_o   <= 32'h00000000;
            running_o <= 1'b0;
            synced_o  <= 1'b0;
        end
        else
        begin
            running_o <= running;
            synced_o  <= measure;
            rdata_o   <= 32'h00000000;
            if (rd_i)
            begin
                case (addr_i)
                    `BERC_A_CTRL:     rdata_o <= {23'h000000, ctrl_r};
                    `BERC_A_TGT_BITS: rdata_o <= tgt_bits_r;
                    `BERC_A_TGT_ERRS: rdata_o <= tgt_errs_r;
                    `BERC_A_RESYNC:   rdata_o <= resync_r;
                    `BERC_A_CUSTOM:   rdata_o <= custom_r;
                    `BERC_A_STATUS:   rdata_o <= {27'h0000000, rx_full, sl_cnt_r == `BERC_MAX16, state_r};
                    `BERC_A_RXCNT:    rdata_o <= rx_cnt_r;
                    `BERC_A_ERRCNT:   rdata_o <= err_cnt_r;
                    `BERC_A_SLCNT:    rdata_o <= {16'h0000, sl_cnt_r};
                    `BERC_A_IFACE:    rdata_o <= {31'h00000000, gate_used_r};
                    default:          rdata_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [berc_monitor.sv]
// Port-level assertion checker for the bit error rate checker
`default_nettype none
module berc_monitor (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        link_clk_i,
    input wire logic        link_data_i,
    input wire logic        link_gate_i,
    input wire logic [3:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        running_o,
    input wire logic        synced_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Helpers and defaults
    // ----------------------------------------
    wire start_w = wr_i && addr_i == 4'h1 && wdata_i[0];
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_rdata_idle_zero: assert property (rdata_o != 32'h0 |-> $past(rd_i))
        else $error("read data outside its slot");
    a_unmapped_zero: assert property (rd_i && addr_i > 4'hA |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_synced_in_run: assert property (synced_o |-> running_o)
        else $error("measuring while stopped");
    a_start_runs: assert property (start_w && !wdata_i[1] && !running_o |-> ##[1:2] running_o)
        else $error("start did not begin a run");
    a_stop_halts: assert property (wr_i && addr_i == 4'h1 && wdata_i[1] |-> ##[1:2] !running_o)
        else $error("stop did not halt");
    a_setting_halts: assert property (wr_i && addr_i <= 4'h5 && addr_i != 4'h1 |-> ##[1:2] !running_o)
        else $error("setting write did not halt");
    a_rise_cause: assert property ($rose(running_o) |-> $past(start_w) || $past(start_w, 2))
        else $error("run began without start");
    a_status_onehot: assert property (rd_i && addr_i == 4'h6 |=> $onehot(rdata_o[2:0]))
        else $error("state field not one-hot");
endmodule
`default_nettype wire

// [berc_link_model.sv]
// Behavioural model of the system under test driving clock, data and gate
`default_nettype none
module berc_link_model (
    input  wire logic        go_i,
    input  wire logic [2:0]  kind_i,
    input  wire logic [31:0] word_i,
    input  wire logic [15:0] nbits_i,
    input  wire logic [15:0] err_from_i,
    input  wire logic        gaps_i,
    input  wire logic        gate_low_i,
    output var  logic        link_clk_o,
    output var  logic        link_data_o,
    output var  logic        link_gate_o,
    output var  logic        done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int   p;
    logic b;
    logic gap;
    logic [8:0] pn;

    initial
    begin
        link_clk_o = 1'b0;
        link_data_o = 1'b0;
        link_gate_o = 1'b0;
        done_o = 1'b1;
    end

    // ----------------------------------------
    // One frame; clock stands still between frames
    // ----------------------------------------
    always @(posedge go_i)
    begin
        done_o = 1'b0;
        p = 0;
        pn = 9'h1FF;
        #13;
        for (int i = 0; i < nbits_i; i++)
        begin
            // Gated-off bits carry junk and advance neither pattern nor generator
            gap = gaps_i && (i % 8 == 7);
            case (kind_i)
                3'h0: b = 1'b0;
                3'h1: b = 1'b1;
                3'h2: b = p[0];
                3'h3: b = word_i[p[4:0]];
                default: b = pn[8] ^ pn[4];
            endcase
            link_gate_o = !gate_low_i && !gap;
            link_data_o = b ^ gap ^ (i >= err_from_i && i % 8 == 3);
            p = gap ? p : p + 1;
            pn = gap ? pn : {pn[7:0], pn[8] ^ pn[4]};
            #80;
            link_clk_o = 1'b1;
            #80;
            link_clk_o = 1'b0;
        end
        // Released lines must not keep looking valid
        link_gate_o = 1'b0;
        link_data_o = ~link_data_o;
        done_o = 1'b1;
    end
endmodule
`default_nettype wire

// [berc_top_tb.sv]
// Self-checking testbench for the bit error rate checker
`default_nettype none
module berc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
        $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rd_d = 1'b0;
    logic [3:0]  addr_i;
    logic [31:0] wdata_i;
    logic [31:0] rdata_o;
    logic        running_o;
    logic        synced_o;
    logic        lclk;
    logic        ldat;
    logic        lgate;
    logic        done;
    logic        go;
    logic        gaps;
    logic        glow;
    logic [2:0]  kind;
    logic [31:0] cw;
    logic [15:0] nb;
    logic [15:0] ef;
    logic [63:0] rq[$];
    logic [63:0] ent;
    logic [3:0]  pc[6] = '{4'hA, 4'hB, 4'hC, 4'hD, 4'h0, 4'h5};
    int          num_errors = 0;
    int          n_tests = 0;

    berc_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .link_clk_i(lclk), .link_data_i(ldat),
        .link_gate_i(lgate), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .running_o(running_o), .synced_o(synced_o));
    berc_link_model u_far (.go_i(go), .kind_i(kind), .word_i(cw), .nbits_i(nb), .err_from_i(ef),
        .gaps_i(gaps), .gate_low_i(glow), .link_clk_o(lclk), .link_data_o(ldat),
        .link_gate_o(lgate), .done_o(done));

    always #2 clk_i = ~clk_i;

    // ----------------------------------------
    // Read checker: oldest note against the data slot
    // ----------------------------------------
    always @(posedge clk_i)
    begin
        if (rd_d)
        begin
            ent = rq.pop_front();
            `CHK(rdata_o & ent[31:0], ent[63:32])
        end
        rd_d <= rd_i;
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        rq.push_back({e, m});
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    // Flags are judged well clear of the launching edge
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    task automatic send(input logic [2:0] k, input logic [15:0] n, input logic [15:0] f, input logic g,
                        input logic l);
        @(posedge clk_i);
        kind <= k;
        nb <= n;
        ef <= f;
        gaps <= g;
        glow <= l;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        for (int i = 0; i < n * 41 + 40 && !done; i++)
            @(posedge clk_i);
        `CHK(done, 1'b1)
        settle();
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #360us;
        num_errors++;
        print_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        addr_i = 4'h0;
        wdata_i = 32'h0;
        go = 1'b0;
        kind = 3'h0;
        nb = 16'h0;
        ef = 16'h0;
        gaps = 1'b0;
        glow = 1'b0;
        void'($urandom(63086));
        cw = $urandom();
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        settle();
        `CHK(running_o, 1'b0)
        rd(4'h0, 32'h080);
        rd(4'h2, 32'h000186A0);
        rd(4'h3, 32'h1);
        rd(4'h4, 32'hC8);
        rd(4'h6, 32'h1);
        rd(4'hB, 32'h0);
        $display("test reset done");
        // Fixed, custom and pseudo-random patterns in endless mode lock with no errors
        wr(4'h5, cw);
        for (int i = 0; i < 6; i++)
        begin
            wr(4'h0, {28'h0000002, pc[i]});
            wr(4'h1, 32'h1);
            send((i < 4) ? i[2:0] : 3'h4, 16'd48, 16'hFFFF, 1'b0, 1'b0);
            `CHK(synced_o, 1'b1)
            rd(4'h8, 32'h0);
            wr(4'h1, 32'h2);
        end
        $display("test patterns done");
        // Bit target at its minimum, gate unused and held low
        wr(4'h0, 32'h00C);
        wr(4'h2, 32'd1000);
        wr(4'h1, 32'h1);
        send(3'h2, 16'd1060, 16'hFFFF, 1'b0, 1'b1);
        `CHK(running_o, 1'b0)
        rd(4'h7, 32'd1000);
        rd(4'h8, 32'h0);
        $display("test bit target done");
        // Error target with gate in use and junk in gated-off slots
        wr(4'hA, 32'h1);
        wr(4'h0, 32'h04D);
        wr(4'h3, 32'd3);
        wr(4'h1, 32'h1);
        send(3'h3, 16'd100, 16'd48, 1'b1, 1'b0);
        `CHK(running_o, 1'b0)
        rd(4'h8, 32'd3);
        wr(4'hA, 32'h0);
        $display("test error target done");
        // Sync loss with count clearing on loss
        wr(4'h4, 32'h2);
        wr(4'h0, 32'h1AC);
        wr(4'h1, 32'h1);
        send(3'h2, 16'd48, 16'hFFFF, 1'b0, 1'b0);
        `CHK(synced_o, 1'b1)
        wr(4'hA, 32'h0);
        settle();
        `CHK(running_o, 1'b1)
        wr(4'h1, 32'h4);
        rd(4'h7, 32'h0, 32'hFFFFFFFC);
        send(3'h2, 16'd80, 16'd0, 1'b0, 1'b0);
        `CHK(synced_o, 1'b0)
        `CHK(running_o, 1'b1)
        rd(4'h9, 32'h1);
        rd(4'h7, 32'h0);
        wr(4'h3, 32'd5);
        settle();
        `CHK(running_o, 1'b0)
        $display("test sync loss done");
        // Continuous mode keeps going after an error target is met
        wr(4'h0, 32'h05C);
        wr(4'h3, 32'd1);
        wr(4'h1, 32'h1);
        send(3'h2, 16'd96, 16'd48, 1'b0, 1'b0);
        `CHK(running_o, 1'b1)
        wr(4'h1, 32'h2);
        settle();
        `CHK(running_o, 1'b0)
        $display("test continuous done");
        // Power loss mid-run comes back stopped
        wr(4'h0, 32'h02C);
        wr(4'h1, 32'h1);
        send(3'h2, 16'd40, 16'hFFFF, 1'b0, 1'b0);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        settle();
        `CHK(running_o, 1'b0)
        rd(4'h6, 32'h1);
        repeat (4) @(posedge clk_i);
        $display("test power loss done");
        print_verdict();
    end
endmodule

bind berc_top berc_monitor u_mon (.clk_i(clk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i),
    .link_data_i(link_data_i), .link_gate_i(link_gate_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .running_o(running_o), .synced_o(synced_o));
`default_nettype wire
